/* src/phra_host_port.sv */
// Paged host register port: page select, page map, id, stream slot use, reset.
// Assumes host strobes already decoded to one-cycle synchronous access pulses.
//
// Functional notes
// R1: Low select line write loads page select
// R2: High select line reaches selected page register
// R3: Page holds until page select rewritten
// R4: Host spaces FIFO accesses; fifo backpressures
// R5: Pages 1,2,4 read/write; page 3 read-only
// R6: Pages 5,6 transmit signaling, read/write
// R7: Pages 9,0A receive signaling, read-only, streamed
// R8: Pages 7,8,0B,0C read/write control
// R9: Page 3 register 1F returns identification
// R10: Source bit low takes stream signaling
// R11: Payload streams carry transmit/receive data
// R12: T1 uses 24 of 32 slots
// R13: E1 uses 30 of 32 slots
// R14: Reset by pin or software bit
// R15: Reset lasts one frame; controls zero
// R16: T1 defaults from zeroed controls, ones out
// R17: E1 defaults from zeroed controls, ones out
// R18: Host runs loopback check after reset
// R19: Strap selects host bus style
// R20: Unmapped accesses ignored, read zero
`timescale 1ns/1ps
`include "phra_consts.svh"
module phra_host_port #(
    parameter int RESET_CYCLES = `PHRA_RESET_CYCLES,
    parameter int FIFO_DEPTH   = 32,
    parameter logic [7:0] ID_CODE = 8'h5a // Arbitrary value
) (
    input  wire logic       ref_clk_in,
    input  wire logic       reset_n_in,
    input  wire logic       host_bus_style_strap_in,
    input  wire logic       e1_mode_in,
    input  wire logic       access_in,
    input  wire logic       write_in,
    input  wire logic       page_or_register_select_line_in,
    input  wire logic [3:0] register_index_lines_in,
    input  wire logic [7:0] wdata_in,
    output logic [7:0]      rdata_out,
    output logic            rvalid_out,
    output logic            busy_out,
    output logic            bus_style_out,
    input  wire logic [4:0] slot_in,
    input  wire logic       slot_strobe_in,
    input  wire logic [7:0] payload_input_stream_in,
    input  wire logic [3:0] signaling_input_stream_in,
    input  wire logic [7:0] rx_payload_in,
    input  wire logic [3:0] rx_signaling_in,
    output logic [7:0]      payload_output_stream_out,
    output logic [3:0]      signaling_output_stream_out,
    output logic [7:0]      tx_payload_out,
    output logic [3:0]      tx_signaling_out,
    output logic [4:0]      tx_slot_out,
    output logic            tx_valid_out,
    input  wire logic       tx_ready_in
);
    localparam int NP = 16;
    localparam int RCW = $clog2(RESET_CYCLES + 1);
    // Storage per page; pages 09h/0ah hold receive signaling captured from line
    logic [7:0] regs [NP][16];
    logic [7:0] page_select_register;
    logic [RCW-1:0] rst_cnt;
    phra_pkg::phra_state_e state;
    logic in_reset;
    logic soft_reset;
    logic slot_used;
    logic [3:0] pg;
    logic [3:0] ch;
    logic [7:0] read_val;
    logic fifo_ready;
    logic fifo_valid;
    phra_pkg::phra_slot_s fifo_out;
    phra_pkg::phra_slot_s fifo_in;
    logic [3:0] tx_sig;

    assign in_reset   = state == phra_pkg::PHRA_CLEAR;
    assign pg         = page_select_register[3:0];
    assign ch         = slot_in[3:0];
    assign soft_reset = access_in && write_in && page_or_register_select_line_in && !in_reset
                        && page_select_register == `PHRA_PAGE_MASTER1
                        && {1'b1, register_index_lines_in} == `PHRA_SRST_OFFSET
                        && wdata_in[`PHRA_SRST_BIT]; // see R14

    // Slot usage per line mode
    always_comb begin
        if (e1_mode_in) begin
            slot_used = slot_in != 5'h00 && slot_in != `PHRA_E1_SIG_SLOT; // see R13
        end else begin
            slot_used = slot_in >= 5'h01 && slot_in <= 5'(`PHRA_T1_CHANNELS); // see R12
        end
    end

    // Reset sequencer: one frame of clearing on pin or software request
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state   <= phra_pkg::PHRA_CLEAR;
            rst_cnt <= '0;
        end else begin
            unique case (state)
                phra_pkg::PHRA_RUN: begin
                    if (soft_reset) begin
                        state   <= phra_pkg::PHRA_CLEAR; // see R14
                        rst_cnt <= '0;
                    end
                end
                phra_pkg::PHRA_CLEAR: begin
                    if (rst_cnt == RCW'(RESET_CYCLES - 1)) begin
                        state <= phra_pkg::PHRA_RUN; // see R15
                    end else begin
                        rst_cnt <= rst_cnt + 1'b1;
                    end
                end
            endcase
        end
    end

    // Page select holds until rewritten
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            page_select_register <= `PHRA_PAGE_RESET;
        end else if (in_reset) begin
            page_select_register <= `PHRA_PAGE_RESET;
        end else if (access_in && write_in && !page_or_register_select_line_in) begin
            page_select_register <= wdata_in; // see R1, R3
        end
    end

    function automatic logic page_writable(input logic [7:0] p);
        page_writable = p == `PHRA_PAGE_MASTER1 || p == `PHRA_PAGE_CONTROL || p == `PHRA_PAGE_STATUS // see R5
                     || p == `PHRA_PAGE_TXSIG_A || p == `PHRA_PAGE_TXSIG_B // see R6
                     || p == `PHRA_PAGE_SLOT_A || p == `PHRA_PAGE_SLOT_B
                     || p == `PHRA_PAGE_HDLC0 || p == `PHRA_PAGE_HDLC1; // see R8
    endfunction

    function automatic logic page_mapped(input logic [7:0] p);
        page_mapped = page_writable(p) || p == `PHRA_PAGE_MASTER_RO
                   || p == `PHRA_PAGE_RXSIG_A || p == `PHRA_PAGE_RXSIG_B; // see R7
    endfunction

    // Register storage; clearing runs for the whole reset frame
    genvar gp;
    generate
        for (gp = 0; gp < NP; gp++) begin : g_page
            always_ff @(posedge ref_clk_in) begin
                if (in_reset) begin
                    for (int r = 0; r < 16; r++) begin
                        regs[gp][r] <= `PHRA_CTRL_RESET; // see R15, R16, R17
                    end
                end else if (access_in && write_in && page_or_register_select_line_in
                             && pg == 4'(gp) && page_select_register[7:4] == 4'h0
                             && page_writable(page_select_register)) begin
                    regs[gp][register_index_lines_in] <= wdata_in; // see R2, R20
                end else if (slot_strobe_in && slot_used && (8'(gp) == `PHRA_PAGE_RXSIG_A
                             || 8'(gp) == `PHRA_PAGE_RXSIG_B) && slot_in[4] == 1'(gp - 9)) begin
                    regs[gp][ch] <= {4'h0, rx_signaling_in}; // see R7
                end
            end
        end
    endgenerate

    // Read mux
    always_comb begin
        read_val = 8'h00;
        if (page_select_register == `PHRA_PAGE_MASTER_RO
            && {1'b1, register_index_lines_in} == `PHRA_ID_OFFSET) begin
            read_val = ID_CODE; // see R9
        end else if (page_mapped(page_select_register)) begin
            read_val = regs[pg][register_index_lines_in]; // see R2
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_out  <= 8'h00;
            rvalid_out <= 1'b0;
        end else begin
            rvalid_out <= access_in && !write_in && page_or_register_select_line_in;
            if (access_in && !write_in && page_or_register_select_line_in) begin
                rdata_out <= in_reset ? 8'h00 : read_val; // see R20
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            busy_out      <= 1'b1;
            bus_style_out <= 1'b0;
        end else begin
            busy_out      <= in_reset;
            bus_style_out <= host_bus_style_strap_in; // see R19
        end
    end

    // Transmit signaling source per channel
    always_comb begin
        if (regs[slot_in[4] ? 8 : 7][ch][`PHRA_SIGSRC_BIT]) begin
            tx_sig = regs[slot_in[4] ? 6 : 5][ch][3:0];
        end else begin
            tx_sig = signaling_input_stream_in; // see R10
        end
    end

    // Transmit path buffered; payload and signaling queued while resetting are all ones
    // Signaling rides with its payload so a later frame cannot overwrite a queued nibble
    assign fifo_in = {in_reset ? 4'hf : tx_sig, slot_in,
                      in_reset ? `PHRA_ALL_ONES : payload_input_stream_in}; // see R10, R11, R16, R17

    phra_fifo #(.WIDTH($bits(phra_pkg::phra_slot_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk_in   (ref_clk_in),
        .reset_n_in   (reset_n_in),
        .wr_data_in   (fifo_in),
        .wr_valid_in  (slot_strobe_in && slot_used), // see R12, R13
        .wr_ready_out (fifo_ready),
        .rd_data_out  (fifo_out),
        .rd_valid_out (fifo_valid),
        .rd_ready_in  (tx_ready_in || !tx_valid_out)
    );

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tx_valid_out     <= 1'b0;
            tx_payload_out   <= 8'h00;
            tx_slot_out      <= 5'h00;
            tx_signaling_out <= 4'h0;
        end else if (tx_ready_in || !tx_valid_out) begin
            tx_valid_out     <= fifo_valid; // see R4
            tx_payload_out   <= fifo_out.data;
            tx_slot_out      <= fifo_out.slot;
            tx_signaling_out <= fifo_out.sig;
        end
    end

    // Receive streams; unused slots stay idle high
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            payload_output_stream_out   <= `PHRA_ALL_ONES;
            signaling_output_stream_out <= 4'hf;
        end else if (slot_strobe_in) begin
            payload_output_stream_out   <= slot_used ? rx_payload_in : `PHRA_ALL_ONES; // see R11
            signaling_output_stream_out <= slot_used ? rx_signaling_in : 4'hf; // see R7, R10
        end
    end
endmodule // phra_host_port

/* shared/phra_consts.svh */
// Offsets, page numbers, reset values and timing counts for the paged host port.
// Assumes inclusion by bare name from the package and the design.
`ifndef PHRA_CONSTS_SVH
`define PHRA_CONSTS_SVH
`define PHRA_NUM_PAGES        15
`define PHRA_REGS_PER_PAGE    16
`define PHRA_PAGE_MASTER1     8'h01
`define PHRA_PAGE_CONTROL     8'h02
`define PHRA_PAGE_MASTER_RO   8'h03
`define PHRA_PAGE_STATUS      8'h04
`define PHRA_PAGE_TXSIG_A     8'h05
`define PHRA_PAGE_TXSIG_B     8'h06
`define PHRA_PAGE_SLOT_A      8'h07
`define PHRA_PAGE_SLOT_B      8'h08
`define PHRA_PAGE_RXSIG_A     8'h09
`define PHRA_PAGE_RXSIG_B     8'h0a
`define PHRA_PAGE_HDLC0       8'h0b
`define PHRA_PAGE_HDLC1       8'h0c
`define PHRA_ID_OFFSET        5'h1f
`define PHRA_SRST_OFFSET      5'h1a
`define PHRA_SRST_BIT         0
`define PHRA_SIGSRC_BIT       1
`define PHRA_CTRL_RESET       8'h00
`define PHRA_PAGE_RESET       8'h00
`define PHRA_ALL_ONES         8'hff
`define PHRA_SLOTS            32
`define PHRA_T1_CHANNELS      24
`define PHRA_E1_CHANNELS      30
`define PHRA_E1_SIG_SLOT      5'h10
`define PHRA_RESET_TIME_NS    125000
`define PHRA_CLK_PERIOD_NS    8
`define PHRA_RESET_CYCLES     ((`PHRA_RESET_TIME_NS + `PHRA_CLK_PERIOD_NS - 1) / `PHRA_CLK_PERIOD_NS)
`endif

/* shared/phra_pkg.sv */
// Types shared by the paged host port design.
// Assumes phra_consts.svh on the include path.
`include "phra_consts.svh"
package phra_pkg;
    typedef struct packed {
        logic       write;
        logic       sel_reg;
        logic [3:0] index;
        logic [7:0] data;
    } phra_req_s;
    typedef struct packed {
        logic [3:0] sig;
        logic [4:0] slot;
        logic [7:0] data;
    } phra_slot_s;
    typedef enum logic [1:0] {
        PHRA_RUN   = 2'b01,
        PHRA_CLEAR = 2'b10
    } phra_state_e;
endpackage

/* src/phra_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module phra_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 32
) (
    input  wire logic             ref_clk_in,
    input  wire logic             reset_n_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    input  wire logic             wr_valid_in,
    output logic                  wr_ready_out,
    output logic [WIDTH-1:0]      rd_data_out,
    output logic                  rd_valid_out,
    input  wire logic             rd_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             push;
    logic             pop;
    logic             full;
    logic             empty;
    assign full         = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign empty        = wr_ptr == rd_ptr;
    assign wr_ready_out = !full;
    assign rd_valid_out = !empty;
    assign rd_data_out  = mem[rd_ptr[AW-1:0]];
    assign push         = wr_valid_in && !full;
    assign pop          = rd_ready_in && !empty;
    always_ff @(posedge ref_clk_in) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= wr_data_in;
        end
    end
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule // phra_fifo

/* verification/phra_tx_sink.sv */
// Far-side consumer of the transmit slot stream, able to stall.
// Assumes the tx valid/ready outputs of phra_host_port and one clock.
`timescale 1ns/1ps
module phra_tx_sink (
    input  wire logic       ref_clk_in,
    input  wire logic       reset_n_in,
    input  wire logic       stall_in,
    input  wire logic       tx_valid_in,
    input  wire logic [7:0] tx_payload_in,
    input  wire logic [3:0] tx_signaling_in,
    input  wire logic [4:0] tx_slot_in,
    output logic            tx_ready_out,
    output int              taken_out
);
    logic [7:0] pay_seen [32];
    logic [3:0] sig_seen [32];
    // Ready low while stalled so the FIFO backs up
    assign tx_ready_out = !stall_in;
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            taken_out <= 0;
        end else if (tx_valid_in && tx_ready_out) begin
            pay_seen[tx_slot_in] <= tx_payload_in;
            sig_seen[tx_slot_in] <= tx_signaling_in;
            taken_out <= taken_out + 1;
        end
    end
endmodule // phra_tx_sink

/* verification/phra_host_port_checker.sv */
// Concurrent checks on the paged host port pins.
// Assumes binding onto phra_host_port in one clock domain.
`timescale 1ns/1ps
module phra_host_port_checker #(
    parameter int RESET_CYCLES = 8
) (
    input wire logic       ref_clk_in,
    input wire logic       reset_n_in,
    input wire logic       host_bus_style_strap_in,
    input wire logic       e1_mode_in,
    input wire logic       access_in,
    input wire logic       write_in,
    input wire logic       page_or_register_select_line_in,
    input wire logic [7:0] rdata_out,
    input wire logic       rvalid_out,
    input wire logic       busy_out,
    input wire logic       bus_style_out,
    input wire logic [4:0] slot_in,
    input wire logic       slot_strobe_in,
    input wire logic [7:0] rx_payload_in,
    input wire logic [3:0] rx_signaling_in,
    input wire logic [7:0] payload_output_stream_out,
    input wire logic [3:0] signaling_output_stream_out,
    input wire logic [7:0] tx_payload_out,
    input wire logic       tx_valid_out,
    input wire logic       tx_ready_in
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    logic        rd_req;
    logic        used;
    logic [15:0] busy_cnt;
    assign rd_req = access_in && !write_in && page_or_register_select_line_in;
    assign used = e1_mode_in ? (slot_in != 5'h00 && slot_in != 5'h10) : (slot_in != 5'h00 && slot_in <= 5'h18);
    // Counts high cycles of busy to bound the reset frame
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            busy_cnt <= 16'h0000;
        end else begin
            busy_cnt <= busy_out ? busy_cnt + 16'h0001 : 16'h0000;
        end
    end
    chk_read_answer: assert property (rd_req |=> rvalid_out)
        else $error("no read answer");
    chk_no_spurious: assert property (!rd_req |=> !rvalid_out)
        else $error("answer without read");
    chk_rdata_hold: assert property (!rvalid_out |-> $stable(rdata_out))
        else $error("read data moved");
    chk_style_copy: assert property ($stable(host_bus_style_strap_in) |=> bus_style_out == $past(host_bus_style_strap_in))
        else $error("bus style wrong");
    chk_t1_unused: assert property (slot_strobe_in && !e1_mode_in && !used |=> payload_output_stream_out == 8'hff && signaling_output_stream_out == 4'hf)
        else $error("t1 idle slot not ones");
    chk_e1_unused: assert property (slot_strobe_in && e1_mode_in && !used |=> payload_output_stream_out == 8'hff && signaling_output_stream_out == 4'hf)
        else $error("e1 idle slot not ones");
    chk_rx_stream: assert property (slot_strobe_in && used && !busy_out |=> payload_output_stream_out == $past(rx_payload_in) && signaling_output_stream_out == $past(rx_signaling_in))
        else $error("rx stream mismatch");
    chk_tx_hold: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_payload_out))
        else $error("tx item dropped");
    chk_reset_span: assert property ($fell(busy_out) |-> busy_cnt >= RESET_CYCLES)
        else $error("reset frame short");
    chk_reset_bound: assert property (busy_cnt <= RESET_CYCLES + 4)
        else $error("reset frame long");
endmodule // phra_host_port_checker
bind phra_host_port phra_host_port_checker #(.RESET_CYCLES(RESET_CYCLES)) u_chk (
    .ref_clk_in, .reset_n_in, .host_bus_style_strap_in, .e1_mode_in, .access_in, .write_in,
    .page_or_register_select_line_in, .rdata_out, .rvalid_out, .busy_out, .bus_style_out, .slot_in,
    .slot_strobe_in, .rx_payload_in, .rx_signaling_in, .payload_output_stream_out,
    .signaling_output_stream_out, .tx_payload_out, .tx_valid_out, .tx_ready_in
);

/* verification/phra_host_port_tb.sv */
// Self-checking bench for the paged host port.
// Assumes phra_tx_sink as far side; the checker is bound separately.
`timescale 1ns/1ps
module phra_host_port_tb;
    localparam int         RC = 8;
    localparam logic [7:0] ID = 8'h3c; // Arbitrary value
    logic       ref_clk_in, reset_n_in, host_bus_style_strap_in, e1_mode_in, access_in, write_in;
    logic       page_or_register_select_line_in, slot_strobe_in, stall, rvalid_out, busy_out;
    logic       bus_style_out, tx_valid_out, tx_ready_in;
    logic [3:0] register_index_lines_in, signaling_input_stream_in, rx_signaling_in;
    logic [3:0] signaling_output_stream_out, tx_signaling_out;
    logic [7:0] wdata_in, rdata_out, payload_input_stream_in, rx_payload_in, payload_output_stream_out;
    logic [7:0] tx_payload_out;
    logic [4:0] slot_in, tx_slot_out;
    int         n_errors, checked, taken, base;
    logic [7:0] rw [9] = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0b, 8'h0c};
    phra_host_port #(.RESET_CYCLES(RC), .ID_CODE(ID)) u_dut (
        .ref_clk_in, .reset_n_in, .host_bus_style_strap_in, .e1_mode_in, .access_in, .write_in,
        .page_or_register_select_line_in, .register_index_lines_in, .wdata_in, .rdata_out, .rvalid_out,
        .busy_out, .bus_style_out, .slot_in, .slot_strobe_in, .payload_input_stream_in,
        .signaling_input_stream_in, .rx_payload_in, .rx_signaling_in, .payload_output_stream_out,
        .signaling_output_stream_out, .tx_payload_out, .tx_signaling_out, .tx_slot_out, .tx_valid_out,
        .tx_ready_in);
    phra_tx_sink u_sink (.ref_clk_in, .reset_n_in, .stall_in(stall), .tx_valid_in(tx_valid_out),
        .tx_payload_in(tx_payload_out), .tx_signaling_in(tx_signaling_out), .tx_slot_in(tx_slot_out),
        .tx_ready_out(tx_ready_in), .taken_out(taken));
    task automatic complete_run();
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic op(input logic w, input logic s, input logic [3:0] idx, input logic [7:0] d);
        @(posedge ref_clk_in);
        access_in <= 1'b1;
        write_in <= w;
        page_or_register_select_line_in <= s;
        register_index_lines_in <= idx;
        wdata_in <= d;
        @(posedge ref_clk_in);
        access_in <= 1'b0;
        @(posedge ref_clk_in); // Idle cycle between accesses
    endtask
    task automatic rd(input string what, input logic [3:0] idx, input logic [7:0] exp);
        op(1'b0, 1'b1, idx, 8'h00);
        chk(what, exp, rdata_out);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 100 && busy_out !== 1'b0; i++) @(posedge ref_clk_in);
        chk("busy", 8'h00, {7'h00, busy_out});
    endtask
    function automatic logic used(input logic e, input int s);
        return e ? (s != 0 && s != 16) : (s >= 1 && s <= 24);
    endfunction
    task automatic strm(input logic e);
        for (int s = 0; s < 32; s++) begin
            @(posedge ref_clk_in);
            e1_mode_in <= e;
            slot_in <= 5'(s);
            slot_strobe_in <= 1'b1;
            rx_payload_in <= 8'(s) ^ 8'ha0;
            rx_signaling_in <= 4'(s);
            payload_input_stream_in <= 8'(s) + 8'h40;
            @(posedge ref_clk_in);
            slot_strobe_in <= 1'b0;
            @(negedge ref_clk_in);
            chk("payload out", used(e, s) ? 8'(s) ^ 8'ha0 : 8'hff, payload_output_stream_out);
            chk("sig out", {4'h0, used(e, s) ? 4'(s) : 4'hf}, {4'h0, signaling_output_stream_out});
        end
    endtask
    initial begin
        ref_clk_in = 1'b0;
        forever #4 ref_clk_in = ~ref_clk_in;
    end
    initial begin
        repeat (20000) @(posedge ref_clk_in);
        n_errors++;
        complete_run();
    end
    initial begin
        {reset_n_in, e1_mode_in, access_in, write_in, page_or_register_select_line_in, slot_strobe_in} = '0;
        {register_index_lines_in, wdata_in, slot_in, payload_input_stream_in, rx_payload_in} = '0;
        {rx_signaling_in, n_errors, checked} = '0;
        signaling_input_stream_in = 4'h9;
        host_bus_style_strap_in = 1'b1;
        stall = 1'b0;
        repeat (12) @(posedge ref_clk_in);
        reset_n_in <= 1'b1;
        wait_idle();
        chk("bus style", 8'h01, {7'h00, bus_style_out});
        op(1'b1, 1'b0, 4'h5, 8'h03);
        rd("id", 4'hf, ID);
        op(1'b1, 1'b1, 4'hf, 8'h00);
        rd("id kept", 4'hf, ID);
        foreach (rw[i]) begin
            op(1'b1, 1'b0, 4'h0, rw[i]);
            rd("rw reset", 4'h3, 8'h00);
            op(1'b1, 1'b1, 4'h3, {rw[i][3:0], 4'h6});
            rd("rw page", 4'h3, {rw[i][3:0], 4'h6});
        end
        foreach (rw[i]) begin
            op(1'b1, 1'b0, 4'h0, i < 2 ? 8'h09 + 8'(i) : 8'h0d + 8'(i));
            op(1'b1, 1'b1, 4'h2, 8'h77);
            rd("ro page", 4'h2, 8'h00);
        end
        stall <= 1'b1;
        strm(1'b0);
        stall <= 1'b0;
        repeat (120) @(posedge ref_clk_in);
        chk("t1 taken", 8'd24, 8'(taken));
        chk("tx pay", 8'h43, u_sink.pay_seen[3]);
        chk("tx reg sig", 8'h06, {4'h0, u_sink.sig_seen[3]});
        chk("tx reg sig b", 8'h06, {4'h0, u_sink.sig_seen[19]});
        chk("tx strm sig", 8'h09, {4'h0, u_sink.sig_seen[4]});
        base = taken;
        stall <= 1'b1;
        strm(1'b1);
        strm(1'b1);
        stall <= 1'b0;
        repeat (150) @(posedge ref_clk_in);
        // One item parked in the output stage, then 32 queued; the rest are refused
        chk("fifo refused", 8'd33, 8'(taken - base));
        op(1'b1, 1'b0, 4'h0, 8'h09);
        rd("rx sig page", 4'h5, 8'h05);
        op(1'b1, 1'b0, 4'h0, 8'h01);
        op(1'b1, 1'b1, 4'ha, 8'h01);
        @(negedge ref_clk_in);
        chk("busy soft", 8'h01, {7'h00, busy_out});
        @(posedge ref_clk_in);
        slot_in <= 5'h05;
        slot_strobe_in <= 1'b1;
        @(posedge ref_clk_in);
        slot_strobe_in <= 1'b0;
        wait_idle();
        repeat (4) @(posedge ref_clk_in);
        chk("tx ones pay", 8'hff, u_sink.pay_seen[5]);
        chk("tx ones sig", 8'h0f, {4'h0, u_sink.sig_seen[5]});
        op(1'b1, 1'b1, 4'h3, 8'h5a);
        rd("page cleared", 4'h3, 8'h00);
        op(1'b1, 1'b0, 4'h0, 8'h07);
        rd("ctrl cleared", 4'h3, 8'h00);
        op(1'b1, 1'b0, 4'h0, 8'h01);
        op(1'b1, 1'b1, 4'h5, 8'h40);
        rd("loopback bit", 4'h5, 8'h40);
        host_bus_style_strap_in <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
        chk("bus style low", 8'h00, {7'h00, bus_style_out});
        complete_run();
    end
endmodule // phra_host_port_tb
